// >>> design/iss_pkg.sv
package iss_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAIT   = 8'h04;
  localparam logic [7:0] ADDR_PWM_LO = 8'h08;
  localparam logic [7:0] ADDR_PWM_HI = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_CHECK_BIT = 0;
  localparam int CTRL_DIAG_BIT  = 1;
  localparam int CTRL_AUTO_BIT  = 2;

  // status register fields
  localparam int STAT_STBY_BIT   = 0;
  localparam int STAT_WAKE_BIT   = 1;
  localparam int STAT_FFREE_BIT  = 2;
  localparam int STAT_FBU_BIT    = 3;
  localparam int STAT_MSG_BIT    = 4;
  localparam int STAT_UNLOCK_BIT = 5;
  localparam int STAT_HIGH_BIT   = 6;
  localparam int STAT_FREQ_LSB   = 8;

  // switching frequency in 0.1 kHz units
  localparam logic [7:0] FREQ_MIN    = 8'h19;
  localparam logic [7:0] FREQ_LO_MAX = 8'h64;
  localparam logic [7:0] FREQ_HI_MAX = 8'hA0;
  localparam logic [7:0] FREQ_LO_RST = 8'h50;
  localparam logic [7:0] FREQ_HI_RST = 8'hA0;

  // reset values
  localparam logic [7:0] WAIT_RST = 8'h3C;
  localparam logic       CHK_RST  = 1'b1;
  localparam logic       AUTO_RST = 1'b1;

  // timing
  localparam longint CLK_HZ        = 64'd250_000_000;
  localparam longint READY_DLY_MS  = 64'd3000;
  localparam longint ESC_HOLD_MS   = 64'd5000;
  localparam longint SECOND_MS     = 64'd1000;
  localparam longint READY_DLY_CYC = READY_DLY_MS * CLK_HZ / 64'd1000;
  localparam longint ESC_HOLD_CYC  = ESC_HOLD_MS * CLK_HZ / 64'd1000;
  localparam longint SECOND_CYC    = SECOND_MS * CLK_HZ / 64'd1000;

  typedef enum logic [1:0] {
    ISS_READY   = 2'b00,
    ISS_STANDBY = 2'b01,
    ISS_WAKE    = 2'b11
  } iss_state_t;

endpackage

// >>> design/iss_input_sync.sv
`timescale 1ns/100ps
module iss_input_sync
  import iss_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gSync
      logic stage1_r;
      logic stage2_r;
      logic stage3_r;
      logic level_r;
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          stage1_r <= 1'b0;
          stage2_r <= 1'b0;
          stage3_r <= 1'b0;
        end else begin
          stage1_r <= pinIn[i];
          stage2_r <= stage1_r;
          stage3_r <= stage2_r;
        end
      end
      // a change counts only once two later stages agree
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          level_r <= 1'b0;
        end else if (stage2_r == stage3_r) begin
          level_r <= stage3_r;
        end
      end
      assign levelOut[i] = level_r;
    end
  endgenerate

endmodule

// >>> design/iss_standby_seq.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module iss_standby_seq
  import iss_pkg::*;
#(
  parameter int unsigned READY_CYC  = 32'(READY_DLY_CYC),
  parameter int unsigned ESC_CYC    = 32'(ESC_HOLD_CYC),
  parameter int unsigned SECOND_LEN = 32'(SECOND_CYC)
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData_r,
  // pins from the lift controller and keypad
  input  wire logic        standbyReqPin,
  input  wire logic        driveEnableSignal,
  input  wire logic        setKeyPin,
  input  wire logic        escKeyPin,
  // events from the drive logic, same clock
  input  wire logic        endOfTravel,
  input  wire logic        checkMsgEvent,
  input  wire logic        diagDone,
  input  wire logic        freqFallback,
  // outputs
  output logic             faultFreeOutput_r,
  output logic             feedbackUnitControlOutput_r,
  output logic             standbyActive_r,
  output logic             checkMsgPending_r,
  output logic             freqUnlocked_r,
  output logic      [7:0]  pwmFreq_r
);

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]  syncLevel;
  logic        standbyReq;
  logic        driveEnable;
  logic        setKey;
  logic        escKey;
  logic        setKeyPrev_r;
  logic        setKeyPress;

  iss_input_sync #(.WIDTH(4)) uSync (
    .mclk     (mclk),
    .reset    (reset),
    .pinIn    ({escKeyPin, setKeyPin, driveEnableSignal, standbyReqPin}),
    .levelOut (syncLevel)
  );

  assign standbyReq  = syncLevel[0];
  assign driveEnable = syncLevel[1];
  assign setKey      = syncLevel[2];
  assign escKey      = syncLevel[3];
  assign setKeyPress = setKey && !setKeyPrev_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      setKeyPrev_r <= 1'b0;
    end else begin
      setKeyPrev_r <= setKey;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  logic       autoParamCheckEnable_r;
  logic       autoParamDiagEnable_r;
  logic       autoMode_r;
  logic [7:0] waitTime_r;
  logic [7:0] pwmLo_r;
  logic [7:0] pwmHi_r;
  logic [7:0] wrByte;
  logic       wrCtrl;

  assign wrByte = regWrData[7:0];
  assign wrCtrl = regWrite && (regAddr == ADDR_CTRL);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      autoParamCheckEnable_r <= CHK_RST;
      autoMode_r             <= AUTO_RST;
      waitTime_r             <= WAIT_RST;
    end else begin
      if (wrCtrl) begin
        autoParamCheckEnable_r <= regWrData[CTRL_CHECK_BIT];
        autoMode_r             <= regWrData[CTRL_AUTO_BIT];
      end
      if (regWrite && regAddr == ADDR_WAIT) begin
        waitTime_r <= wrByte;
      end
    end
  end

  // diagnostics run finishing wins over a write in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      autoParamDiagEnable_r <= 1'b0;
    end else if (diagDone) begin
      autoParamDiagEnable_r <= 1'b0;
    end else if (wrCtrl) begin
      autoParamDiagEnable_r <= regWrData[CTRL_DIAG_BIT];
    end
  end

  // frequency settings locked until unlocked; out-of-range writes clamp
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwmLo_r <= FREQ_LO_RST;
      pwmHi_r <= FREQ_HI_RST;
    end else if (regWrite && freqUnlocked_r) begin
      if (regAddr == ADDR_PWM_LO) begin
        pwmLo_r <= (wrByte < FREQ_MIN) ? FREQ_MIN :
                   (wrByte > FREQ_LO_MAX) ? FREQ_LO_MAX : wrByte;
      end
      if (regAddr == ADDR_PWM_HI) begin
        pwmHi_r <= (wrByte < FREQ_MIN) ? FREQ_MIN :
                   (wrByte > FREQ_HI_MAX) ? FREQ_HI_MAX : wrByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // escape hold unlock, stays unlocked until reset
  logic [31:0] escCnt_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      escCnt_r       <= 32'h0;
      freqUnlocked_r <= 1'b0;
    end else if (!escKey) begin
      escCnt_r <= 32'h0;
    end else if (escCnt_r == ESC_CYC - 1) begin
      freqUnlocked_r <= 1'b1;
    end else begin
      escCnt_r <= escCnt_r + 32'h1;
    end
  end

  // frequency selection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwmFreq_r <= FREQ_HI_RST;
    end else if (autoMode_r && !freqFallback) begin
      pwmFreq_r <= pwmHi_r;
    end else begin
      pwmFreq_r <= pwmLo_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter check message; a new message wins over the acknowledge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      checkMsgPending_r <= 1'b0;
    end else if (checkMsgEvent && (autoParamCheckEnable_r || autoParamDiagEnable_r)) begin
      checkMsgPending_r <= 1'b1;
    end else if (setKeyPress) begin
      checkMsgPending_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive standby sequencing
  iss_state_t  state_r;
  iss_state_t  state_nxt;
  logic [31:0] wakeCnt_r;
  logic        wakeDone;

  assign wakeDone = (wakeCnt_r == READY_CYC - 1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ISS_READY: begin
        if (standbyReq && !driveEnable) begin
          state_nxt = ISS_STANDBY;
        end
      end
      ISS_STANDBY: begin
        if (!standbyReq) begin
          state_nxt = ISS_WAKE;
        end
      end
      ISS_WAKE: begin
        if (standbyReq && !driveEnable) begin
          state_nxt = ISS_STANDBY;
        end else if (wakeDone) begin
          state_nxt = ISS_READY;
        end
      end
      default: begin
        state_nxt = ISS_READY;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ISS_READY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wakeCnt_r <= 32'h0;
    end else if (state_r == ISS_WAKE) begin
      wakeCnt_r <= wakeCnt_r + 32'h1;
    end else begin
      wakeCnt_r <= 32'h0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      faultFreeOutput_r <= 1'b1;
      standbyActive_r   <= 1'b0;
    end else begin
      faultFreeOutput_r <= (state_nxt == ISS_READY);
      standbyActive_r   <= (state_nxt == ISS_STANDBY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feedback unit standby; travel start wakes it at once, since the unit
  // needs a second before it can take regenerated energy
  logic        fbuArmed_r;
  logic [31:0] secCnt_r;
  logic [7:0]  secLeft_r;
  logic        secTick;

  assign secTick = (secCnt_r == SECOND_LEN - 1);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      secCnt_r <= 32'h0;
    end else if (!fbuArmed_r || secTick || endOfTravel) begin
      secCnt_r <= 32'h0;
    end else begin
      secCnt_r <= secCnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fbuArmed_r                  <= 1'b0;
      secLeft_r                   <= 8'h0;
      feedbackUnitControlOutput_r <= 1'b1;
    end else if (waitTime_r == 8'h0 || driveEnable) begin
      fbuArmed_r                  <= 1'b0;
      feedbackUnitControlOutput_r <= 1'b1;
    end else if (endOfTravel) begin
      fbuArmed_r <= 1'b1;
      secLeft_r  <= waitTime_r;
    end else if (fbuArmed_r && secTick) begin
      if (secLeft_r == 8'h1) begin
        fbuArmed_r                  <= 1'b0;
        feedbackUnitControlOutput_r <= 1'b0;
      end else begin
        secLeft_r <= secLeft_r - 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data valid only in the cycle after the strobe
  logic [31:0] rdValue;

  always_comb begin
    rdValue = 32'h0;
    case (regAddr)
      ADDR_CTRL: begin
        rdValue[CTRL_CHECK_BIT] = autoParamCheckEnable_r;
        rdValue[CTRL_DIAG_BIT]  = autoParamDiagEnable_r;
        rdValue[CTRL_AUTO_BIT]  = autoMode_r;
      end
      ADDR_WAIT:   rdValue[7:0] = waitTime_r;
      ADDR_PWM_LO: rdValue[7:0] = pwmLo_r;
      ADDR_PWM_HI: rdValue[7:0] = pwmHi_r;
      ADDR_STATUS: begin
        rdValue[STAT_STBY_BIT]   = standbyActive_r;
        rdValue[STAT_WAKE_BIT]   = (state_r == ISS_WAKE);
        rdValue[STAT_FFREE_BIT]  = faultFreeOutput_r;
        rdValue[STAT_FBU_BIT]    = feedbackUnitControlOutput_r;
        rdValue[STAT_MSG_BIT]    = checkMsgPending_r;
        rdValue[STAT_UNLOCK_BIT] = freqUnlocked_r;
        rdValue[STAT_HIGH_BIT]   = (pwmFreq_r == pwmHi_r) && autoMode_r;
        rdValue[STAT_FREQ_LSB +: 8] = pwmFreq_r;
      end
      default: rdValue = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regRdData_r <= 32'h0;
    end else begin
      regRdData_r <= regRead ? rdValue : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  noStandbyEnabled_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ISS_READY && driveEnable) |=> state_r != ISS_STANDBY)
    else $error("standby entered while drive enabled");

  standbyEntry_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ISS_READY && standbyReq && !driveEnable) |=> standbyActive_r)
    else $error("standby request not taken");

  faultOff_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r != ISS_READY) |-> !faultFreeOutput_r)
    else $error("fault-free output high outside ready");

  wakeReady_a: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ISS_WAKE && wakeDone && !standbyReq) |=> faultFreeOutput_r
      && state_r == ISS_READY && $past(wakeCnt_r) == READY_CYC - 1)
    else $error("ready not restored after wake delay");

  fbuOffCause_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(feedbackUnitControlOutput_r) |-> $past(fbuArmed_r) && $past(secTick)
      && $past(secLeft_r) == 8'h1)
    else $error("feedback output dropped without wait expiry");

  fbuZeroWait_a: assert property (@(posedge mclk) disable iff (reset)
    (waitTime_r == 8'h0) |=> feedbackUnitControlOutput_r)
    else $error("feedback output inactive with zero wait");

  msgHold_a: assert property (@(posedge mclk) disable iff (reset)
    (checkMsgPending_r && !setKeyPress) |=> checkMsgPending_r)
    else $error("check message cleared without set key");

  apdClear_a: assert property (@(posedge mclk) disable iff (reset)
    diagDone |=> !autoParamDiagEnable_r)
    else $error("diagnostics enable survived a completed run");

  freqRange_a: assert property (@(posedge mclk) disable iff (reset)
    pwmLo_r >= FREQ_MIN && pwmLo_r <= FREQ_LO_MAX && pwmHi_r >= FREQ_MIN
      && pwmHi_r <= FREQ_HI_MAX)
    else $error("switching frequency out of range");

  unlockHold_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(freqUnlocked_r) |-> $past(escKey) && $past(escCnt_r) == ESC_CYC - 1)
    else $error("frequency unlocked without full escape hold");

  freqSelect_a: assert property (@(posedge mclk) disable iff (reset)
    (autoMode_r && !freqFallback) |=> pwmFreq_r == $past(pwmHi_r))
    else $error("auto mode not on high frequency");

endmodule

// >>> verif/iss_fbu_model.sv
`timescale 1ns/100ps
module iss_fbu_model
  import iss_pkg::*;
#(
  parameter int unsigned SECOND_LEN = 5
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // control from the drive, high keeps the unit running
  input  wire logic fbuCtrl,
  // unit status towards the bench
  output logic      unitReady_r
);
  int unsigned wakeCnt_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wakeCnt_r   <= 0;
      unitReady_r <= 1'b1;
    end else if (!fbuCtrl) begin
      wakeCnt_r   <= 0;
      unitReady_r <= 1'b0;
    end else if (!unitReady_r) begin
      // not ready until a full second after control returns
      if (wakeCnt_r == SECOND_LEN - 1) unitReady_r <= 1'b1;
      wakeCnt_r <= wakeCnt_r + 1;
    end
  end
endmodule

// >>> verif/iss_standby_seq_tb.sv
`timescale 1ns/100ps
module iss_standby_seq_tb;
  import iss_pkg::*;
  localparam int unsigned RC = 20;
  localparam int unsigned EC = 10;
  localparam int unsigned SL = 5;
  logic        mclk, reset, regWrite, regRead, standbyReqPin, driveEnableSignal;
  logic        setKeyPin, escKeyPin, endOfTravel, checkMsgEvent, diagDone, freqFallback;
  logic        faultFree, fbuCtrl, standbyActive, msgPending, unlocked, unitReady;
  logic [7:0]  regAddr, pwmFreq, lo, hi;
  logic [31:0] regWrData, regRdData, rdv;
  int          errors, checksDone, seed, n;

  iss_standby_seq #(.READY_CYC(RC), .ESC_CYC(EC), .SECOND_LEN(SL)) dut_u (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_r(regRdData),
    .standbyReqPin(standbyReqPin), .driveEnableSignal(driveEnableSignal),
    .setKeyPin(setKeyPin), .escKeyPin(escKeyPin), .endOfTravel(endOfTravel),
    .checkMsgEvent(checkMsgEvent), .diagDone(diagDone), .freqFallback(freqFallback),
    .faultFreeOutput_r(faultFree), .feedbackUnitControlOutput_r(fbuCtrl),
    .standbyActive_r(standbyActive), .checkMsgPending_r(msgPending),
    .freqUnlocked_r(unlocked), .pwmFreq_r(pwmFreq));

  iss_fbu_model #(.SECOND_LEN(SL)) fbu_u (
    .mclk(mclk), .reset(reset), .fbuCtrl(fbuCtrl), .unitReady_r(unitReady));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  //////////////////////////////////////////////////////////////////////////////
  task stopTest;
    if (errors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge mclk);
    regWrite  <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task pulse(input int w);
    @(posedge mclk);
    case (w)
      0: endOfTravel <= 1'b1;
      1: checkMsgEvent <= 1'b1;
      default: diagDone <= 1'b1;
    endcase
    @(posedge mclk);
    endOfTravel   <= 1'b0;
    checkMsgEvent <= 1'b0;
    diagDone      <= 1'b0;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return standbyActive;
      1: return faultFree;
      2: return fbuCtrl;
      3: return msgPending;
      4: return unlocked;
      default: return unitReady;
    endcase
  endfunction

  // cycles until the picked output reaches v; lim+1 means it never did
  task waitv(input int w, input logic v, input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge mclk);
      #1;
      if (pick(w) === v) break;
    end
  endtask

  function automatic logic [7:0] clampf(input logic [7:0] v, input logic [7:0] mx);
    return (v < FREQ_MIN) ? FREQ_MIN : ((v > mx) ? mx : v);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 20000);
    errors++;
    stopTest();
  end

  initial begin
    {regWrite, regRead, standbyReqPin, driveEnableSignal, setKeyPin} = '0;
    {escKeyPin, endOfTravel, checkMsgEvent, diagDone, freqFallback} = '0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    errors = 0;
    checksDone = 0;
    seed = 87;
    reset = 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_CTRL, rdv);
    chk("ctrl reset", rdv, 32'h0000_0005);
    rd(ADDR_STATUS, rdv);
    chk("status reset", rdv, 32'h0000_A04C);
    rd(ADDR_WAIT, rdv);
    chk("wait reset", rdv, {24'h0, WAIT_RST});
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, rdv);
    chk("unmapped read", rdv, 32'h0);
    // request while the drive is enabled must be ignored
    @(posedge mclk);
    driveEnableSignal <= 1'b1;
    standbyReqPin     <= 1'b1;
    waitv(0, 1'b1, 12, n);
    chk("standby refused", n, 13);
    chk("fault free kept", faultFree, 1'b1);
    @(posedge mclk);
    driveEnableSignal <= 1'b0;
    waitv(0, 1'b1, 12, n);
    chk("standby entry time", n >= 3 && n <= 8, 1'b1);
    chk("fault free in standby", faultFree, 1'b0);
    @(posedge mclk);
    standbyReqPin <= 1'b0;
    waitv(1, 1'b1, 40, n);
    chk("ready delay", n >= RC + 2 && n <= RC + 8, 1'b1);
    // feedback unit wait from end of travel
    wr(ADDR_WAIT, 32'h2);
    pulse(0);
    waitv(2, 1'b0, 20, n);
    chk("fbu wait", n >= 2 * SL - 2 && n <= 2 * SL + 2, 1'b1);
    @(posedge mclk);
    #1 chk("unit standby", unitReady, 1'b0);
    wr(ADDR_WAIT, 32'h0);
    waitv(2, 1'b1, 4, n);
    chk("fbu zero wait", n <= 2, 1'b1);
    waitv(5, 1'b1, 10, n);
    chk("unit wake", n, SL);
    pulse(0);
    waitv(2, 1'b0, 30, n);
    chk("fbu held", n, 31);
    wr(ADDR_WAIT, 32'h1);
    pulse(0);
    waitv(2, 1'b0, 12, n);
    chk("fbu one second", n, SL);
    @(posedge mclk);
    driveEnableSignal <= 1'b1;
    waitv(2, 1'b1, 8, n);
    chk("fbu on enable", n <= 8, 1'b1);
    @(posedge mclk);
    driveEnableSignal <= 1'b0;
    // message held until the set key
    pulse(1);
    waitv(3, 1'b1, 3, n);
    chk("msg raised", n <= 3, 1'b1);
    repeat (10) @(posedge mclk);
    #1;
    chk("msg held", msgPending, 1'b1);
    @(posedge mclk);
    setKeyPin <= 1'b1;
    waitv(3, 1'b0, 8, n);
    chk("msg ack", n <= 8, 1'b1);
    @(posedge mclk);
    setKeyPin <= 1'b0;
    wr(ADDR_CTRL, 32'h7);
    rd(ADDR_CTRL, rdv);
    chk("diag on", rdv, 32'h7);
    pulse(2);
    rd(ADDR_CTRL, rdv);
    chk("diag self clear", rdv, 32'h5);
    // locked write is dropped, then unlock by holding escape
    wr(ADDR_PWM_LO, 32'h30);
    rd(ADDR_PWM_LO, rdv);
    chk("locked write", rdv, {24'h0, FREQ_LO_RST});
    @(posedge mclk);
    escKeyPin <= 1'b1;
    waitv(4, 1'b1, EC + 10, n);
    chk("unlock hold", n >= EC && n <= EC + 8, 1'b1);
    @(posedge mclk);
    escKeyPin <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      lo = (i == 0) ? 8'h80 : ((i == 1) ? 8'h05 : 8'($random(seed)));
      hi = (i == 0) ? 8'hFF : ((i == 1) ? 8'h10 : 8'($random(seed)));
      wr(ADDR_PWM_LO, {24'h0, lo});
      wr(ADDR_PWM_HI, {24'h0, hi});
      rd(ADDR_PWM_LO, rdv);
      chk("low freq", rdv, {24'h0, clampf(lo, FREQ_LO_MAX)});
      rd(ADDR_PWM_HI, rdv);
      chk("high freq", rdv, {24'h0, clampf(hi, FREQ_HI_MAX)});
      lo = clampf(lo, FREQ_LO_MAX);
      hi = clampf(hi, FREQ_HI_MAX);
      @(posedge mclk);
      freqFallback <= i[0];
      repeat (3) @(posedge mclk);
      #1;
      chk("auto freq", pwmFreq, i[0] ? lo : hi);
    end
    wr(ADDR_CTRL, 32'h1);
    freqFallback <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("fixed freq", pwmFreq, clampf(lo, FREQ_LO_MAX));
    // with both checks switched off no message may be raised
    wr(ADDR_CTRL, 32'h0);
    pulse(1);
    waitv(3, 1'b1, 4, n);
    chk("msg gated", n, 5);
    stopTest();
  end
endmodule
